/* File: rtl/clc_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef CLC_MAP_SVH
`define CLC_MAP_SVH

`define CLC_OFF_GAIN       4'h0
`define CLC_OFF_ATTEN      4'h1
`define CLC_OFF_CTRL       4'h2
`define CLC_OFF_PIO        4'h3
`define CLC_OFF_STATUS     4'h4
`define CLC_OFF_MONITOR    4'h5

`define CLC_CTRL_MIC_BYP   0
`define CLC_CTRL_BOOST_OFF 1
`define CLC_CTRL_MUTE_LINE 2
`define CLC_CTRL_MUTE_SPK  3
`define CLC_CTRL_SRC       4
`define CLC_CTRL_MCK_LO    5
`define CLC_CTRL_MCK_HI    6
`define CLC_CTRL_DIV_LO    7
`define CLC_CTRL_DIV_HI    9

`define CLC_CTRL_RST       10'h000
`define CLC_PIO_RST        2'h3
`define CLC_GAIN_MAX       4'hf
`define CLC_ATTEN_MAX      6'h3f
`define CLC_ZC_TIMEOUT     9'h1ff
`define CLC_CAL_FRAMES     8'hc2
`define CLC_MIC_BOOST_DB   20
`define CLC_SPK_BOOST_DB   3
`define CLC_MCLK_STOP_NS   5000
`define CLC_MCLK_PERIOD_NS 8
`define CLC_MCLK_STOP_CYC  (`CLC_MCLK_STOP_NS / `CLC_MCLK_PERIOD_NS)

`endif

/* File: rtl/clc_pkg.sv */
// types shared by the level, calibration and clock control block
package clc_pkg;
   typedef enum logic [2:0] {
      CLC_CAL_IDLE = 3'b001,
      CLC_CAL_RUN  = 3'b010,
      CLC_CAL_DONE = 3'b100
   } clc_cal_t;

   typedef struct packed {
      logic [15:0] left;
      logic [15:0] right;
   } clc_stereo_t;

   typedef struct packed {
      logic [3:0]  gain_req;
      logic [5:0]  atten_req;
      logic [9:0]  ctrl;
      logic [1:0]  pio_out;
      logic [3:0]  mon_att;
      logic [7:0]  gain_act;
      logic [11:0] atten_act;
      logic [8:0]  gain_tmo;
      logic [8:0]  atten_tmo;
      logic [15:0] adc_prev_l;
      logic [15:0] adc_prev_r;
      logic [15:0] dac_prev_l;
      logic [15:0] dac_prev_r;
      clc_cal_t    cal;
      logic [7:0]  cal_cnt;
      logic        data_mode_d;
      logic        fs_d;
      logic [1:0]  pio_in;
      logic [9:0]  mclk_idle;
      logic        filt_off;
      logic [15:0] rd_data;
      clc_stereo_t dac_mix;
      logic [2:0]  rdiv;
      logic        rclk;
      logic        rclk_run;
      logic [15:0] frame_cnt;
      logic [15:0] frame_len;
      logic [1:0]  pio_pend;
      logic        pio_pend_v;
   } clc_state_t;
endpackage

/* File: rtl/clc_core.sv */
// level stepping, mute/boost, monitor mix, calibration, pio and clock control
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "clc_map.svh"

// Operation
// R1: bypass bit removes 20 dB mic stage
// R2: input gain 0..22.5 dB, 1.5 dB steps
// R3: gain applied at zero crossing, 511-frame forcing
// R4: attenuation 0..94.5 dB, zero crossing, forced
// R5: line/headphone mute; speaker sum, own mute
// R6: boost-off clear adds 3 dB headphone/speaker
// R7: monitor attenuated ADC added to DAC, clipped
// R8: calibrate on leaving reset
// R9: calibrate when data mode select rises
// R10: calibration 194 frames, serial data zero
// R11: invalid flag high during calibration only
// R12: during calibration ignore control except source; the code ignores source select writes too
// R13: controller waits 50 ms before calibration
// R14: pio open drain, zero drives low
// R15: pio readable control, read/write data mode
// R16: pio timing tied to frame edges; the code samples the pins on the bit clock in control mode
// R17: filters off on clock or frame stop
// R18: unselected crystal oscillator powered down
// R19: rate clock glitch-free 256x frame rate
// R20: rate clock stops low after control mode
// R21: rate clock duty per divide code
// R22: controller derives frames from rate clock
// R23: zero crossing is sign change; restart timeout
module clc_core
#(
   parameter int CAL_FRAMES = 194,
   parameter int ZC_FRAMES  = 511
)
(
   input  wire logic               i_mclk,
   input  wire logic               i_sys_rst,
   input  wire logic [3:0]         i_addr,
   input  wire logic [15:0]        i_wdata,
   input  wire logic               i_wr,
   input  wire logic               i_rd,
   output logic [15:0]             o_rdata,
   input  wire logic               i_data_mode,
   input  wire logic               i_frame_sync,
   input  wire logic               i_frame_valid,
   input  wire logic               i_bit_clk_rise,
   input  wire logic               i_mclk_tick,
   input  wire clc_pkg::clc_stereo_t i_adc,
   input  wire clc_pkg::clc_stereo_t i_dac_in,
   input  wire logic [15:0]        i_ser_out,
   output logic [15:0]             o_serial_data_output,
   output clc_pkg::clc_stereo_t    o_dac_mix,
   output logic                    o_conversion_invalid_flag,
   output logic                    o_mic_boost_on,
   output logic [7:0]              o_in_gain,
   output logic [11:0]             o_out_atten,
   output logic                    o_line_en,
   output logic                    o_spk_en,
   output logic                    o_hp_spk_boost,
   output logic                    o_spk_boost,
   output logic                    o_cal_input_src,
   input  wire logic [1:0]         i_pio,
   output logic [1:0]              o_pio,
   output logic [1:0]              o_pio_oe_n,
   output logic                    o_filt_pd,
   output logic                    o_first_crystal_oscillator_pd,
   output logic                    o_second_crystal_oscillator_pd,
   output logic                    o_rate_clock_output
);

   clc_pkg::clc_state_t s_reg;
   clc_pkg::clc_state_t s_next;

   logic       cal_busy;
   logic       frame_rise;
   logic [1:0] mck_sel;
   logic [2:0] div_code;
   logic [1:0]  gain_zc;
   logic [1:0]  atten_zc;
   logic [15:0] adc_cur [2];
   logic [15:0] adc_old [2];
   logic [15:0] dac_cur [2];
   logic [15:0] dac_old [2];
   logic [16:0] sum_l;
   logic [16:0] sum_r;
   logic [15:0] mon_l;
   logic [15:0] mon_r;
   logic [2:0]  div_len;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] clip16(input logic [16:0] v);
      if (v[16] != v[15])
         clip16 = v[16] ? 16'h8000 : 16'h7fff;
      else
         clip16 = v[15:0];
   endfunction

   // one crossing detector per channel: index 1 is left, 0 is right
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_zc
         assign gain_zc[ch]  = adc_cur[ch][15] != adc_old[ch][15]; // [R23]
         assign atten_zc[ch] = dac_cur[ch][15] != dac_old[ch][15]; // [R23]
      end
   endgenerate

   always_comb
   begin
      cal_busy   = (s_reg.cal == clc_pkg::CLC_CAL_RUN);
      frame_rise = i_frame_sync & ~s_reg.fs_d;
      mck_sel    = s_reg.ctrl[`CLC_CTRL_MCK_HI:`CLC_CTRL_MCK_LO];
      div_code   = s_reg.ctrl[`CLC_CTRL_DIV_HI:`CLC_CTRL_DIV_LO];
      // samples feeding the per-channel crossing detectors
      adc_cur[1] = i_adc.left;
      adc_cur[0] = i_adc.right;
      adc_old[1] = s_reg.adc_prev_l;
      adc_old[0] = s_reg.adc_prev_r;
      dac_cur[1] = i_dac_in.left;
      dac_cur[0] = i_dac_in.right;
      dac_old[1] = s_reg.dac_prev_l;
      dac_old[0] = s_reg.dac_prev_r;

      // monitor level is an arithmetic right shift of the converter samples
      mon_l = $signed(i_adc.left) >>> s_reg.mon_att;
      mon_r = $signed(i_adc.right) >>> s_reg.mon_att;
      sum_l = {i_dac_in.left[15], i_dac_in.left} + {mon_l[15], mon_l}; // [R7]
      sum_r = {i_dac_in.right[15], i_dac_in.right} + {mon_r[15], mon_r};
      // codes 3 and 5 divide by three: high one of three periods
      case (div_code)
         3'h3, 3'h5: div_len = 3'h2;
         default:    div_len = 3'h1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // next state: bus, pins, levels, calibration and clocks
   always_comb
   begin
      s_next = s_reg;
      s_next.fs_d = i_frame_sync;
      s_next.data_mode_d = i_data_mode;
      s_next.rd_data = 16'h0000;

      // a pending data mode pin write lands on the frame start; a write in
      // the same cycle stays pending for the next frame
      if (i_data_mode && frame_rise && s_reg.pio_pend_v)
      begin
         s_next.pio_out    = s_reg.pio_pend; // [R16]
         s_next.pio_pend_v = 1'b0;
      end

      // register writes; calibration keeps all control, source select included
      if (i_wr)
      begin
         // only the source bit would matter here, and it must stay put
         if (cal_busy)
         begin
            if (i_addr == `CLC_OFF_CTRL)
               s_next.ctrl[`CLC_CTRL_SRC] = s_reg.ctrl[`CLC_CTRL_SRC]; // [R12]
         end
         else if (i_addr == `CLC_OFF_GAIN)
         begin
            s_next.gain_req = i_wdata[3:0]; // [R2]
            s_next.gain_tmo = 9'h000; // [R23]
         end
         else if (i_addr == `CLC_OFF_ATTEN)
         begin
            s_next.atten_req = i_wdata[5:0]; // [R4]
            s_next.atten_tmo = 9'h000; // [R23]
         end
         else if (i_addr == `CLC_OFF_CTRL)
            s_next.ctrl = i_wdata[9:0];
         else if (i_addr == `CLC_OFF_PIO && i_data_mode)
         begin
            s_next.pio_pend   = i_wdata[1:0]; // [R15]
            s_next.pio_pend_v = 1'b1;
         end
         else if (i_addr == `CLC_OFF_MONITOR)
            s_next.mon_att = i_wdata[3:0];
      end

      // read data stand for one cycle only, zero otherwise
      if (i_rd)
      begin
         if (i_addr == `CLC_OFF_GAIN)
            s_next.rd_data = {12'h000, s_reg.gain_req};
         else if (i_addr == `CLC_OFF_ATTEN)
            s_next.rd_data = {10'h000, s_reg.atten_req};
         else if (i_addr == `CLC_OFF_CTRL)
            s_next.rd_data = {6'h00, s_reg.ctrl};
         else if (i_addr == `CLC_OFF_PIO)
            s_next.rd_data = {12'h000, s_reg.pio_out, s_reg.pio_in}; // [R15]
         else if (i_addr == `CLC_OFF_STATUS)
            s_next.rd_data = {13'h0000, s_reg.filt_off, cal_busy,
                              s_reg.cal == clc_pkg::CLC_CAL_DONE};
         else if (i_addr == `CLC_OFF_MONITOR)
            s_next.rd_data = {12'h000, s_reg.mon_att};
      end

      // pio sampling: data mode on frame edge, control mode on bit clock
      // control mode reads therefore come back within the same frame
      if (i_data_mode ? frame_rise : i_bit_clk_rise)
         s_next.pio_in = i_pio; // [R16]

      // per-frame level stepping; each channel has its own crossing detector
      if (i_frame_valid)
      begin
         s_next.adc_prev_l = i_adc.left;
         s_next.adc_prev_r = i_adc.right;
         s_next.dac_prev_l = i_dac_in.left;
         s_next.dac_prev_r = i_dac_in.right;

         // input gain: left in the upper nibble, right in the lower
         if (s_reg.gain_act != {s_reg.gain_req, s_reg.gain_req})
         begin
            if (s_reg.gain_tmo == 9'(ZC_FRAMES - 1))
            begin
               // no crossing in time: force both channels
               s_next.gain_act = {s_reg.gain_req, s_reg.gain_req}; // [R3]
               s_next.gain_tmo = 9'h000;
            end
            else
            begin
               s_next.gain_tmo = s_reg.gain_tmo + 9'h001; // [R3]
               if (gain_zc[1])
                  s_next.gain_act[7:4] = s_reg.gain_req; // [R3]
               if (gain_zc[0])
                  s_next.gain_act[3:0] = s_reg.gain_req; // [R3]
            end
         end

         // output attenuation: left in the upper six bits, right below
         if (s_reg.atten_act != {s_reg.atten_req, s_reg.atten_req})
         begin
            if (s_reg.atten_tmo == 9'(ZC_FRAMES - 1))
            begin
               // no crossing in time: force both channels
               s_next.atten_act = {s_reg.atten_req, s_reg.atten_req}; // [R4]
               s_next.atten_tmo = 9'h000;
            end
            else
            begin
               s_next.atten_tmo = s_reg.atten_tmo + 9'h001; // [R4]
               if (atten_zc[1])
                  s_next.atten_act[11:6] = s_reg.atten_req; // [R4]
               if (atten_zc[0])
                  s_next.atten_act[5:0] = s_reg.atten_req; // [R4]
            end
         end

         // monitor mix clips instead of wrapping
         s_next.dac_mix.left  = clip16(sum_l); // [R7]
         s_next.dac_mix.right = clip16(sum_r);
      end

      // calibration sequencer
      case (s_reg.cal)
         // armed by reset: start at once
         clc_pkg::CLC_CAL_IDLE:
         begin
            s_next.cal = clc_pkg::CLC_CAL_RUN; // [R8]
            s_next.cal_cnt = 8'h00;
         end
         // count frame starts; the last one ends calibration
         clc_pkg::CLC_CAL_RUN:
         begin
            if (frame_rise)
            begin
               if (s_reg.cal_cnt == 8'(CAL_FRAMES - 1))
                  s_next.cal = clc_pkg::CLC_CAL_DONE; // [R10]
               else
                  s_next.cal_cnt = s_reg.cal_cnt + 8'h01;
            end
         end
         // stay done until the next data mode entry
         clc_pkg::CLC_CAL_DONE:
         begin
            if (i_data_mode && !s_reg.data_mode_d)
               s_next.cal = clc_pkg::CLC_CAL_IDLE; // [R9]
         end
         default: s_next.cal = clc_pkg::CLC_CAL_IDLE;
      endcase
      // entering data mode restarts calibration from any state
      if (i_data_mode && !s_reg.data_mode_d)
      begin
         s_next.cal = clc_pkg::CLC_CAL_RUN; // [R9]
         s_next.cal_cnt = 8'h00;
      end

      // idle detection: master clock ticks and frame edges
      // the master clock counts as stopped after a fixed time without ticks
      if (i_mclk_tick)
         s_next.mclk_idle = 10'h000;
      else if (s_reg.mclk_idle != 10'(`CLC_MCLK_STOP_CYC))
         s_next.mclk_idle = s_reg.mclk_idle + 10'h001;

      // a frame gap longer than the last measured period means frames stopped
      if (i_frame_valid)
      begin
         s_next.frame_cnt = 16'h0000;
         s_next.frame_len = s_reg.frame_cnt;
      end
      else if (s_reg.frame_cnt != 16'hffff)
         s_next.frame_cnt = s_reg.frame_cnt + 16'h0001;
      // filters only; the rest of the block keeps running
      s_next.filt_off = (s_reg.mclk_idle == 10'(`CLC_MCLK_STOP_CYC))
                      | (s_reg.frame_cnt > s_reg.frame_len); // [R17]

      // rate clock divider; runs only on master clock ticks, so a source
      // switch changes only the tick timing and cannot chop a high phase
      if (i_mclk_tick)
      begin
         if (s_reg.rdiv >= div_len)
         begin
            s_next.rdiv = 3'h0;
            // run state changes only at a period boundary, never mid-pulse
            s_next.rclk_run = i_data_mode; // [R20]
            s_next.rclk = i_data_mode; // [R19]
         end
         else
         begin
            s_next.rdiv = s_reg.rdiv + 3'h1;
            // low for the rest of the period: 50% on divide by two,
            // high one third on divide by three
            s_next.rclk = 1'b0; // [R21]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         // control cleared, pins released, calibration armed
         s_reg           <= '0;
         s_reg.ctrl      <= `CLC_CTRL_RST;
         s_reg.pio_out   <= `CLC_PIO_RST;
         s_reg.cal       <= clc_pkg::CLC_CAL_IDLE; // [R8]
      end
      else
         s_reg <= s_next;
   end

   ////////////////////////////////////////////////////////////////////////
   assign o_rdata                   = s_reg.rd_data;
   assign o_serial_data_output      = cal_busy ? 16'h0000 : i_ser_out; // [R10]
   assign o_conversion_invalid_flag = cal_busy; // [R11]
   assign o_dac_mix                 = s_reg.dac_mix;
   // analog settings from the control register and the applied gain and attenuation levels
   assign o_mic_boost_on            = ~s_reg.ctrl[`CLC_CTRL_MIC_BYP]; // [R1]
   assign o_in_gain                 = s_reg.gain_act;
   assign o_out_atten               = s_reg.atten_act;
   assign o_line_en                 = ~s_reg.ctrl[`CLC_CTRL_MUTE_LINE]; // [R5]
   assign o_spk_en                  = ~s_reg.ctrl[`CLC_CTRL_MUTE_SPK]; // [R5]
   assign o_hp_spk_boost            = ~s_reg.ctrl[`CLC_CTRL_BOOST_OFF]; // [R6]
   assign o_spk_boost               = ~s_reg.ctrl[`CLC_CTRL_BOOST_OFF]; // [R6]
   assign o_cal_input_src           = s_reg.ctrl[`CLC_CTRL_SRC]; // [R12]
   // pins never drive high; the enable alone pulls them low
   assign o_pio                     = 2'h0;
   assign o_pio_oe_n                = s_reg.pio_out; // [R14]
   // power and clocks
   assign o_filt_pd                 = s_reg.filt_off; // [R17]
   assign o_first_crystal_oscillator_pd                = (mck_sel != 2'h1); // [R18]
   assign o_second_crystal_oscillator_pd                = (mck_sel != 2'h2); // [R18]
   assign o_rate_clock_output       = s_reg.rclk & s_reg.rclk_run; // [R19]

endmodule
`default_nettype wire

/* File: test/clc_core_props.sv */
// assertion checker for the level, calibration and clock control block
`timescale 1ns/1ns
`default_nettype none
`include "clc_map.svh"
module clc_core_props
(
   input wire logic        i_mclk,
   input wire logic        i_sys_rst,
   input wire logic [3:0]  i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_data_mode,
   input wire logic [15:0] o_serial_data_output,
   input wire logic        o_conversion_invalid_flag,
   input wire logic        o_mic_boost_on,
   input wire logic        o_spk_boost,
   input wire logic        o_cal_input_src,
   input wire logic [1:0]  o_pio,
   input wire logic [1:0]  o_pio_oe_n,
   input wire logic        o_first_crystal_oscillator_pd,
   input wire logic        o_second_crystal_oscillator_pd,
   input wire logic        o_rate_clock_output
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   // control writes only count outside calibration
   wire logic ctl_wr = i_wr && i_addr == `CLC_OFF_CTRL && !o_conversion_invalid_flag;
   logic [6:0] idle_reg;
   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst || i_data_mode)
         idle_reg <= 7'h00;
      else if (idle_reg != 7'h7f)
         idle_reg <= idle_reg + 7'h01;
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_ser_quiet: assert property (o_conversion_invalid_flag |-> o_serial_data_output == 16'h0000)
      else $error("serial data not zero while calibrating");
   a_cal_on_mode: assert property ($rose(i_data_mode) |=> o_conversion_invalid_flag)
      else $error("no calibration after data mode entry");
   a_cal_on_rst: assert property ($fell(i_sys_rst) |=> ##[0:1] o_conversion_invalid_flag)
      else $error("no calibration after reset");
   a_pio_rst_val: assert property (disable iff (1'b0) i_sys_rst |=> o_pio_oe_n == 2'h3)
      else $error("pins not released by reset");
   a_pio_drain: assert property (o_pio == 2'h0)
      else $error("pin driven high");
   a_mic_ctl: assert property (ctl_wr |=> o_mic_boost_on == !$past(i_wdata[0]))
      else $error("mic stage does not follow bypass bit");
   a_spk_boost: assert property (ctl_wr |=> o_spk_boost == !$past(i_wdata[1]))
      else $error("speaker boost does not follow boost bit");
   a_xtal_sel: assert property (ctl_wr && i_wdata[6:5] == 2'h1 |=> !o_first_crystal_oscillator_pd && o_second_crystal_oscillator_pd)
      else $error("wrong oscillator powered down");
   a_src_hold: assert property (o_conversion_invalid_flag && $past(o_conversion_invalid_flag)
      |-> $stable(o_cal_input_src))
      else $error("source changed during calibration");
   a_rclk_stop: assert property (idle_reg >= 7'h40 |-> !o_rate_clock_output)
      else $error("rate clock still running in control mode");
   c_cal: cover property ($rose(o_conversion_invalid_flag));
   c_ctl: cover property (ctl_wr);
   c_rclk: cover property ($rose(o_rate_clock_output));
endmodule
`default_nettype wire

/* File: test/clc_far_end.sv */
// far-end controller model: frame timing and audio samples
`timescale 1ns/1ns
`default_nettype none
module clc_far_end
(
   input  wire logic            i_mclk,
   input  wire logic            i_run,
   input  wire logic            i_flip,
   input  wire logic [15:0]     i_samp,
   output logic                 o_frame_sync,
   output logic                 o_frame_valid,
   output logic                 o_bit_clk_rise,
   output logic                 o_mclk_tick,
   output clc_pkg::clc_stereo_t o_adc,
   output clc_pkg::clc_stereo_t o_dac
);
   logic [5:0]  cnt_reg = 6'h00;
   logic        odd_reg = 1'b0;
   logic [15:0] s;
   // frames derived from the master tick count, so they stay locked to it
   always_ff @(posedge i_mclk)
   begin
      cnt_reg <= cnt_reg + 6'h01;
      if (cnt_reg == 6'h3f)
         odd_reg <= ~odd_reg;
   end
   assign o_mclk_tick    = cnt_reg[0];
   assign o_bit_clk_rise = cnt_reg[1:0] == 2'h0;
   assign o_frame_sync   = i_run && cnt_reg < 6'h08;
   assign o_frame_valid  = i_run && cnt_reg == 6'h00;
   // alternating sign gives a crossing on every frame
   assign s     = (i_flip && odd_reg) ? -i_samp : i_samp;
   assign o_adc = {s, s};
   assign o_dac = {s, s};
endmodule
`default_nettype wire

/* File: test/clc_core_tb_top.sv */
// self-checking bench for the level, calibration and clock control block
`timescale 1ns/1ns
`default_nettype none
`include "clc_map.svh"
module clc_core_tb_top;
   localparam int CAL_FRAMES = 4;
   localparam int ZC_FRAMES  = 8;
   logic        i_mclk      = 1'b0;
   logic        i_sys_rst   = 1'b1;
   logic [3:0]  i_addr      = 4'h0;
   logic [15:0] i_wdata     = 16'h0000;
   logic        i_wr        = 1'b0;
   logic        i_rd        = 1'b0;
   logic        i_data_mode = 1'b0;
   logic [15:0] i_ser_out   = 16'ha5a5;
   logic        run         = 1'b1;
   logic        flip        = 1'b0;
   logic [15:0] samp        = 16'h1000;
   int          failures    = 0;
   int          check_count = 0;
   int          cycles      = 0;
   wire logic   i_frame_sync, i_frame_valid, i_bit_clk_rise, i_mclk_tick;
   wire logic   o_conversion_invalid_flag, o_mic_boost_on, o_line_en, o_spk_en;
   wire logic   o_hp_spk_boost, o_spk_boost, o_cal_input_src, o_filt_pd;
   wire logic   o_first_crystal_oscillator_pd, o_second_crystal_oscillator_pd, o_rate_clock_output;
   wire logic [15:0] o_rdata, o_serial_data_output;
   wire logic [7:0]  o_in_gain;
   wire logic [11:0] o_out_atten;
   wire logic [1:0]  o_pio, o_pio_oe_n, i_pio;
   wire clc_pkg::clc_stereo_t i_adc, i_dac_in, o_dac_mix;
   // pull-ups on both pins
   assign i_pio = o_pio_oe_n | o_pio;
   always #4 i_mclk = ~i_mclk;
   ////////////////////////////////////////////////////////////////////////////////
   clc_core #(.CAL_FRAMES(CAL_FRAMES), .ZC_FRAMES(ZC_FRAMES)) clc_core_i
   (
      .i_mclk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_data_mode,
      .i_frame_sync, .i_frame_valid, .i_bit_clk_rise, .i_mclk_tick, .i_adc, .i_dac_in,
      .i_ser_out, .o_serial_data_output, .o_dac_mix, .o_conversion_invalid_flag,
      .o_mic_boost_on, .o_in_gain, .o_out_atten, .o_line_en, .o_spk_en, .o_hp_spk_boost,
      .o_spk_boost, .o_cal_input_src, .i_pio, .o_pio, .o_pio_oe_n, .o_filt_pd,
      .o_first_crystal_oscillator_pd, .o_second_crystal_oscillator_pd, .o_rate_clock_output
   );
   clc_far_end clc_far_end_i
   (
      .i_mclk, .i_run(run), .i_flip(flip), .i_samp(samp), .o_frame_sync(i_frame_sync),
      .o_frame_valid(i_frame_valid), .o_bit_clk_rise(i_bit_clk_rise),
      .o_mclk_tick(i_mclk_tick), .o_adc(i_adc), .o_dac(i_dac_in)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge i_mclk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= v;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge i_mclk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask
   task automatic frames(input int n);
      repeat (n)
         @(posedge i_frame_valid);
      @(posedge i_mclk);
      #1;
   endtask
   // counts frame starts seen while the invalid flag stands
   task automatic cal_wait();
      int   n;
      logic p;
      n = 0;
      repeat (3)
         @(posedge i_mclk);
      #1;
      p = i_frame_sync;
      chk(16'(o_conversion_invalid_flag), 16'h0001);
      while (o_conversion_invalid_flag === 1'b1 && n < 99)
      begin
         if (i_frame_sync && !p)
            n++;
         p = i_frame_sync;
         @(posedge i_mclk);
         #1;
      end
      chk(16'(n), 16'(CAL_FRAMES));
   endtask
   always @(posedge i_mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      // long reset hold stands in for reference settling
      repeat (12)
         @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      cal_wait();
      $display("test reset calibration done");
      rd(4'hf, 16'h0000);
      rd(`CLC_OFF_CTRL, 16'h0000);
      wr(`CLC_OFF_CTRL, 16'h0023);
      rd(`CLC_OFF_CTRL, 16'h0023);
      chk(16'({o_mic_boost_on, o_spk_boost, o_second_crystal_oscillator_pd}), 16'h0001);
      wr(`CLC_OFF_CTRL, 16'h0044);
      @(posedge i_mclk);
      #1;
      chk(16'({o_hp_spk_boost, o_spk_boost, o_line_en, o_spk_en, o_first_crystal_oscillator_pd}), 16'h001b);
      $display("test control bits done");
      wr(`CLC_OFF_PIO, 16'h0000);
      frames(2);
      chk(16'(o_pio_oe_n), 16'h0003);
      rd(`CLC_OFF_PIO, 16'h000f);
      frames(1);
      @(posedge i_mclk);
      i_data_mode <= 1'b1;
      cal_wait();
      wr(`CLC_OFF_PIO, 16'h0002);
      frames(2);
      chk(16'(o_pio_oe_n), 16'h0002);
      rd(`CLC_OFF_PIO, 16'h000a);
      $display("test pins done");
      wr(`CLC_OFF_GAIN, 16'h0005);
      frames(3);
      chk(16'(o_in_gain), 16'h0000);
      frames(ZC_FRAMES);
      chk(16'(o_in_gain), 16'h0055);
      flip <= 1'b1;
      wr(`CLC_OFF_ATTEN, 16'h002a);
      frames(2);
      chk(16'(o_out_atten), 16'h0aaa);
      $display("test levels done");
      flip <= 1'b0;
      samp <= 16'h7fff;
      wr(`CLC_OFF_MONITOR, 16'h0000);
      frames(2);
      chk(o_dac_mix.left, 16'h7fff);
      @(posedge i_mclk);
      i_data_mode <= 1'b0;
      repeat (100)
         @(posedge i_mclk);
      #1;
      chk(16'(o_rate_clock_output), 16'h0000);
      run <= 1'b0;
      repeat (200)
         @(posedge i_mclk);
      #1;
      chk(16'(o_filt_pd), 16'h0001);
      $display("test monitor and clocks done");
      results();
   end
endmodule
bind clc_core clc_core_props clc_core_props_i
(
   .i_mclk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_data_mode, .o_serial_data_output,
   .o_conversion_invalid_flag, .o_mic_boost_on, .o_spk_boost, .o_cal_input_src, .o_pio,
   .o_pio_oe_n, .o_first_crystal_oscillator_pd, .o_second_crystal_oscillator_pd, .o_rate_clock_output
);
`default_nettype wire
